// file: rtl/calt_alu.sv
// arithmetic and logic execution unit with state-accurate timing, apb slave
// Overview of operation
// [RQ1] one state equals two clock cycles
// [RQ2] short inc/dec: binary 2, source 1
// [RQ3] dword inc 4/3, dec 5/4 states
// [RQ4] indirect byte inc/dec: binary 3, source 4
// [RQ5] direct rmw adds 2 io, 3 peripheral
// [RQ6] external byte adds N+2, word twice
// [RQ7] acc logic direct: 1, +1 io, +2 peripheral
// [RQ8] word register logic: 3 binary, 2 source
// [RQ9] immediate16 logic into word: 4/3 states
// [RQ10] rotate left through carry, one state
// [RQ11] rotate right through carry, one state
// [RQ12] plain rotates wrap bit, carry untouched
// [RQ13] nibble swap, two states both modes
// [RQ14] shifts by one: binary 2, source 1
// [RQ15] mul ab: b high, acc low, 5
// [RQ16] byte mul 6/5, double-width product
// [RQ17] word mul: 12 binary, 11 source
// [RQ18] div ab: quotient acc, remainder b, 10
// [RQ19] register div: quotient high, remainder low
// [RQ20] div byte 11/10, word 21/20 states
// [RQ21] decimal adjust both nibbles, one state
`timescale 1ns/1ps
module calt_alu (
	// clock and reset
	input wire logic clk,
	input wire logic rst_b,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// status
	output logic busy
);
	calt_pkg::calt_ctrl_s ctrl_r;
	logic [31:0] opa_r;
	logic [31:0] opb_r;
	logic [31:0] res_lo_r;
	logic [31:0] res_hi_r;
	logic carry_r;
	logic aux_r;
	logic divz_r;
	logic done_r;
	logic [7:0] last_states_r;
	logic [31:0] rd_nxt;
	logic err_nxt;
	logic setup;
	logic wr_acc;
	logic start_req;
	logic timer_done;
	logic [7:0] states_nxt;
	logic [7:0] ext_add;
	logic [31:0] lo_nxt;
	logic [31:0] hi_nxt;
	logic carry_nxt;
	logic divz_nxt;
	logic [31:0] step_val;
	calt_pkg::calt_op_e op_c;

	assign setup = psel && !penable;
	assign wr_acc = psel && penable && pwrite;
	assign pready = 1'b1;
	assign start_req = wr_acc && (paddr == calt_pkg::CALT_ADDR_CTRL) && pwdata[8] && !busy;
	assign op_c = ctrl_r.op;

	calt_state_timer #(
		.SW(calt_pkg::CALT_SW),
		.CPS(calt_pkg::CALT_CLKS_PER_STATE)
	) u_timer (
		.clk(clk),
		.rst_b(rst_b),
		.load(start_req),
		.states(states_nxt),
		.busy(busy),
		.done(timer_done)
	); // RQ1

	// timing is taken from the incoming control word so the count is ready at load
	calt_pkg::calt_ctrl_s wc;
	assign wc = calt_pkg::calt_ctrl_s'(pwdata[15:0]);

	always_comb begin
		ext_add = 8'h00;
		if (wc.loc == calt_pkg::CALT_LOC_EXTERNAL) begin
			if (wc.word_size)
				ext_add = 8'(2 * ({4'h0, wc.wait_states} + calt_pkg::CALT_T_EXT_BASE)); // RQ6
			else
				ext_add = {4'h0, wc.wait_states} + calt_pkg::CALT_T_EXT_BASE; // RQ6
		end
	end

	always_comb begin
		states_nxt = calt_pkg::CALT_T_ROT;
		case (wc.op)
			calt_pkg::CALT_OP_INC_SHORT, calt_pkg::CALT_OP_DEC_SHORT:
				states_nxt = wc.source_mode ? calt_pkg::CALT_T_SHORT_S : calt_pkg::CALT_T_SHORT_B; // RQ2
			calt_pkg::CALT_OP_INC_DWORD:
				states_nxt = wc.source_mode ? calt_pkg::CALT_T_INCD_S : calt_pkg::CALT_T_INCD_B; // RQ3
			calt_pkg::CALT_OP_DEC_DWORD:
				states_nxt = wc.source_mode ? calt_pkg::CALT_T_DECD_S : calt_pkg::CALT_T_DECD_B; // RQ3
			calt_pkg::CALT_OP_INC_IND, calt_pkg::CALT_OP_DEC_IND:
				states_nxt = wc.source_mode ? calt_pkg::CALT_T_IND_S : calt_pkg::CALT_T_IND_B; // RQ4
			calt_pkg::CALT_OP_INC_DIR, calt_pkg::CALT_OP_DEC_DIR: begin
				states_nxt = calt_pkg::CALT_T_DIRRMW;
				if (wc.loc == calt_pkg::CALT_LOC_IO_PORT)
					states_nxt = calt_pkg::CALT_T_DIRRMW + calt_pkg::CALT_T_RMW_IO; // RQ5
				else if (wc.loc == calt_pkg::CALT_LOC_PERIPH)
					states_nxt = calt_pkg::CALT_T_DIRRMW + calt_pkg::CALT_T_RMW_PER; // RQ5
			end
			calt_pkg::CALT_OP_AND_ACC_DIR, calt_pkg::CALT_OP_OR_ACC_DIR,
			calt_pkg::CALT_OP_XOR_ACC_DIR: begin
				states_nxt = calt_pkg::CALT_T_ACCDIR;
				if (wc.loc == calt_pkg::CALT_LOC_IO_PORT)
					states_nxt = calt_pkg::CALT_T_ACCDIR + calt_pkg::CALT_T_RD_IO; // RQ7
				else if (wc.loc == calt_pkg::CALT_LOC_PERIPH)
					states_nxt = calt_pkg::CALT_T_ACCDIR + calt_pkg::CALT_T_RD_PER; // RQ7
			end
			calt_pkg::CALT_OP_AND_WREG, calt_pkg::CALT_OP_OR_WREG, calt_pkg::CALT_OP_XOR_WREG:
				states_nxt = wc.source_mode ? calt_pkg::CALT_T_WREG_S : calt_pkg::CALT_T_WREG_B; // RQ8
			calt_pkg::CALT_OP_AND_IMM16, calt_pkg::CALT_OP_OR_IMM16, calt_pkg::CALT_OP_XOR_IMM16:
				states_nxt = wc.source_mode ? calt_pkg::CALT_T_IMM_S : calt_pkg::CALT_T_IMM_B; // RQ9
			calt_pkg::CALT_OP_ROTATE_LEFT, calt_pkg::CALT_OP_ROTATE_RIGHT,
			calt_pkg::CALT_OP_ROTATE_LEFT_CARRY, calt_pkg::CALT_OP_ROTATE_RIGHT_CARRY:
				states_nxt = calt_pkg::CALT_T_ROT; // RQ10 RQ11 RQ12
			calt_pkg::CALT_OP_SWAP:
				states_nxt = calt_pkg::CALT_T_SWAP; // RQ13
			calt_pkg::CALT_OP_SHIFT_LEFT_LOGICAL, calt_pkg::CALT_OP_SHIFT_RIGHT_ARITH,
			calt_pkg::CALT_OP_SHIFT_RIGHT_LOGICAL:
				states_nxt = wc.source_mode ? calt_pkg::CALT_T_SHORT_S : calt_pkg::CALT_T_SHORT_B; // RQ14
			calt_pkg::CALT_OP_MUL_AB:
				states_nxt = calt_pkg::CALT_T_MULAB; // RQ15
			calt_pkg::CALT_OP_MUL_REG:
				if (wc.word_size)
					states_nxt = wc.source_mode ? calt_pkg::CALT_T_MULW_S : calt_pkg::CALT_T_MULW_B; // RQ17
				else
					states_nxt = wc.source_mode ? calt_pkg::CALT_T_MULB_S : calt_pkg::CALT_T_MULB_B; // RQ16
			calt_pkg::CALT_OP_DIV_AB:
				states_nxt = calt_pkg::CALT_T_DIVAB; // RQ18
			calt_pkg::CALT_OP_DIV_REG:
				if (wc.word_size)
					states_nxt = wc.source_mode ? calt_pkg::CALT_T_DIVW_S : calt_pkg::CALT_T_DIVW_B; // RQ20
				else
					states_nxt = wc.source_mode ? calt_pkg::CALT_T_DIVB_S : calt_pkg::CALT_T_DIVB_B; // RQ20
			calt_pkg::CALT_OP_DECIMAL_ADJUST:
				states_nxt = calt_pkg::CALT_T_DA; // RQ21
			default:
				states_nxt = calt_pkg::CALT_T_ROT;
		endcase
		// external operand cost stacks on top of the base count
		states_nxt = states_nxt + ext_add; // RQ6
	end

	always_comb begin
		case (ctrl_r.step)
			calt_pkg::CALT_STEP_2: step_val = 32'h0000_0002;
			calt_pkg::CALT_STEP_4: step_val = 32'h0000_0004;
			default: step_val = 32'h0000_0001;
		endcase
	end

	// result datapath works on latched operands, committed at the end of the count
	logic [8:0] da_lo;
	logic [8:0] da_hi;
	logic da_cy;
	logic [31:0] wrd_sum;
	always_comb begin
		lo_nxt = res_lo_r;
		hi_nxt = res_hi_r;
		carry_nxt = carry_r;
		divz_nxt = divz_r;
		da_lo = {1'b0, opa_r[7:0]};
		da_hi = 9'h000;
		da_cy = carry_r;
		wrd_sum = 32'h0000_0000;
		case (op_c)
			calt_pkg::CALT_OP_INC_SHORT, calt_pkg::CALT_OP_DEC_SHORT: begin
				wrd_sum = (op_c == calt_pkg::CALT_OP_INC_SHORT) ? opa_r + step_val : opa_r - step_val;
				lo_nxt = ctrl_r.word_size ? {16'h0000, wrd_sum[15:0]} : {24'h000000, wrd_sum[7:0]}; // RQ2
			end
			calt_pkg::CALT_OP_INC_DWORD:
				lo_nxt = opa_r + step_val; // RQ3
			calt_pkg::CALT_OP_DEC_DWORD:
				lo_nxt = opa_r - step_val; // RQ3
			calt_pkg::CALT_OP_INC_IND, calt_pkg::CALT_OP_INC_DIR:
				lo_nxt = {24'h000000, opa_r[7:0] + 8'h01}; // RQ4 RQ5
			calt_pkg::CALT_OP_DEC_IND, calt_pkg::CALT_OP_DEC_DIR:
				lo_nxt = {24'h000000, opa_r[7:0] - 8'h01}; // RQ4 RQ5
			calt_pkg::CALT_OP_AND_ACC_DIR:
				lo_nxt = {24'h000000, opa_r[7:0] & opb_r[7:0]}; // RQ7
			calt_pkg::CALT_OP_OR_ACC_DIR:
				lo_nxt = {24'h000000, opa_r[7:0] | opb_r[7:0]}; // RQ7
			calt_pkg::CALT_OP_XOR_ACC_DIR:
				lo_nxt = {24'h000000, opa_r[7:0] ^ opb_r[7:0]}; // RQ7
			calt_pkg::CALT_OP_AND_WREG, calt_pkg::CALT_OP_AND_IMM16:
				lo_nxt = {16'h0000, opa_r[15:0] & opb_r[15:0]}; // RQ8 RQ9
			calt_pkg::CALT_OP_OR_WREG, calt_pkg::CALT_OP_OR_IMM16:
				lo_nxt = {16'h0000, opa_r[15:0] | opb_r[15:0]}; // RQ8 RQ9
			calt_pkg::CALT_OP_XOR_WREG, calt_pkg::CALT_OP_XOR_IMM16:
				lo_nxt = {16'h0000, opa_r[15:0] ^ opb_r[15:0]}; // RQ8 RQ9
			calt_pkg::CALT_OP_ROTATE_LEFT:
				lo_nxt = {24'h000000, opa_r[6:0], opa_r[7]}; // RQ12
			calt_pkg::CALT_OP_ROTATE_RIGHT:
				lo_nxt = {24'h000000, opa_r[0], opa_r[7:1]}; // RQ12
			calt_pkg::CALT_OP_ROTATE_LEFT_CARRY: begin
				lo_nxt = {24'h000000, opa_r[6:0], carry_r}; // RQ10
				carry_nxt = opa_r[7]; // RQ10
			end
			calt_pkg::CALT_OP_ROTATE_RIGHT_CARRY: begin
				lo_nxt = {24'h000000, carry_r, opa_r[7:1]}; // RQ11
				carry_nxt = opa_r[0]; // RQ11
			end
			calt_pkg::CALT_OP_SWAP:
				lo_nxt = {24'h000000, opa_r[3:0], opa_r[7:4]}; // RQ13
			calt_pkg::CALT_OP_SHIFT_LEFT_LOGICAL:
				lo_nxt = ctrl_r.word_size ? {16'h0000, opa_r[14:0], 1'b0}
					: {24'h000000, opa_r[6:0], 1'b0}; // RQ14
			calt_pkg::CALT_OP_SHIFT_RIGHT_ARITH:
				lo_nxt = ctrl_r.word_size ? {16'h0000, opa_r[15], opa_r[15:1]}
					: {24'h000000, opa_r[7], opa_r[7:1]}; // RQ14
			calt_pkg::CALT_OP_SHIFT_RIGHT_LOGICAL:
				lo_nxt = ctrl_r.word_size ? {16'h0000, 1'b0, opa_r[15:1]}
					: {24'h000000, 1'b0, opa_r[7:1]}; // RQ14
			calt_pkg::CALT_OP_MUL_AB, calt_pkg::CALT_OP_MUL_REG: begin
				// b lands in the high byte, accumulator in the low byte, except word mul, whose product fills all 32 bits
				if (ctrl_r.word_size && op_c == calt_pkg::CALT_OP_MUL_REG)
					lo_nxt = 32'(opa_r[15:0]) * 32'(opb_r[15:0]); // RQ17
				else
					lo_nxt = {16'h0000, 16'(opa_r[7:0]) * 16'(opb_r[7:0])}; // RQ15 RQ16
			end
			calt_pkg::CALT_OP_DIV_AB, calt_pkg::CALT_OP_DIV_REG: begin
				// divide by zero leaves the low result untouched and raises a flag
				if (ctrl_r.word_size && op_c == calt_pkg::CALT_OP_DIV_REG) begin
					divz_nxt = (opb_r[15:0] == 16'h0000);
					if (!divz_nxt)
						lo_nxt = {opa_r[15:0] / opb_r[15:0], opa_r[15:0] % opb_r[15:0]}; // RQ19
				end else begin
					divz_nxt = (opb_r[7:0] == 8'h00);
					if (!divz_nxt && op_c == calt_pkg::CALT_OP_DIV_AB)
						lo_nxt = {16'h0000, opa_r[7:0] % opb_r[7:0], opa_r[7:0] / opb_r[7:0]}; // RQ18
					else if (!divz_nxt)
						lo_nxt = {16'h0000, opa_r[7:0] / opb_r[7:0], opa_r[7:0] % opb_r[7:0]}; // RQ19
				end
			end
			calt_pkg::CALT_OP_DECIMAL_ADJUST: begin
				if (opa_r[3:0] > calt_pkg::CALT_BCD_MAX || aux_r)
					da_lo = {1'b0, opa_r[7:0]} + {5'h00, calt_pkg::CALT_BCD_FIX}; // RQ21
				da_cy = carry_r | da_lo[8]; // RQ21
				da_hi = {1'b0, da_lo[7:0]};
				if (da_lo[7:4] > calt_pkg::CALT_BCD_MAX || da_cy)
					da_hi = {1'b0, da_lo[7:0]} + {1'b0, calt_pkg::CALT_BCD_FIX, 4'h0}; // RQ21
				lo_nxt = {24'h000000, da_hi[7:0]};
				carry_nxt = da_cy | da_hi[8]; // RQ21
			end
			default:
				lo_nxt = res_lo_r;
		endcase
		// operand a passes through whole to the high result for every operation
		hi_nxt = opa_r;
	end

	// control word; start bit is a strobe and reads back as zero
	always_ff @(posedge clk) begin
		if (!rst_b)
			ctrl_r <= calt_pkg::calt_ctrl_s'(calt_pkg::CALT_CTRL_RST);
		else if (start_req)
			ctrl_r <= wc;
	end

	// operands are locked while a count runs
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			opa_r <= 32'h0000_0000;
			opb_r <= 32'h0000_0000;
		end else if (wr_acc && !busy) begin
			if (paddr == calt_pkg::CALT_ADDR_OPA)
				opa_r <= pwdata;
			if (paddr == calt_pkg::CALT_ADDR_OPB)
				opb_r <= pwdata;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			res_lo_r <= 32'h0000_0000;
			res_hi_r <= 32'h0000_0000;
		end else if (timer_done) begin
			res_lo_r <= lo_nxt;
			res_hi_r <= hi_nxt;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			carry_r <= 1'b0;
			aux_r <= 1'b0;
			divz_r <= 1'b0;
		end else if (timer_done) begin
			carry_r <= carry_nxt;
			divz_r <= divz_nxt;
		end else if (wr_acc && !busy && paddr == calt_pkg::CALT_ADDR_FLAGS) begin
			carry_r <= pwdata[calt_pkg::CALT_FLAG_CARRY];
			aux_r <= pwdata[calt_pkg::CALT_FLAG_AUX];
			divz_r <= pwdata[calt_pkg::CALT_FLAG_DIVZ];
		end
	end

	// done is sticky; completion in the clearing cycle wins
	always_ff @(posedge clk) begin
		if (!rst_b)
			done_r <= 1'b0;
		else if (timer_done)
			done_r <= 1'b1;
		else if (start_req)
			done_r <= 1'b0;
		else if (wr_acc && paddr == calt_pkg::CALT_ADDR_STATUS && pwdata[calt_pkg::CALT_ST_DONE])
			done_r <= 1'b0;
	end

	always_ff @(posedge clk) begin
		if (!rst_b)
			last_states_r <= 8'h00;
		else if (start_req)
			last_states_r <= states_nxt;
	end

	always_comb begin
		rd_nxt = 32'h0000_0000;
		err_nxt = 1'b0;
		case (paddr)
			calt_pkg::CALT_ADDR_CTRL: rd_nxt = {16'h0000, ctrl_r[15:9], 1'b0, ctrl_r[7:0]};
			calt_pkg::CALT_ADDR_OPA: rd_nxt = opa_r;
			calt_pkg::CALT_ADDR_OPB: rd_nxt = opb_r;
			calt_pkg::CALT_ADDR_FLAGS: rd_nxt = {29'h00000000, divz_r, aux_r, carry_r};
			calt_pkg::CALT_ADDR_RES_LO: rd_nxt = res_lo_r;
			calt_pkg::CALT_ADDR_RES_HI: rd_nxt = res_hi_r;
			calt_pkg::CALT_ADDR_STATUS: rd_nxt = {16'h0000, last_states_r, 6'h00, done_r, busy};
			default: err_nxt = 1'b1;
		endcase
	end

	// read data captured in setup so the access phase needs no wait state
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			prdata <= 32'h0000_0000;
			pslverr <= 1'b0;
		end else if (setup) begin
			prdata <= pwrite ? 32'h0000_0000 : rd_nxt;
			pslverr <= err_nxt;
		end
	end
endmodule // calt_alu

// file: rtl/calt_pkg.sv
// shared constants and types for the arithmetic and logic timing unit
package calt_pkg;
	// apb byte addresses
	localparam logic [7:0] CALT_ADDR_CTRL = 8'h00;
	localparam logic [7:0] CALT_ADDR_OPA = 8'h04;
	localparam logic [7:0] CALT_ADDR_OPB = 8'h08;
	localparam logic [7:0] CALT_ADDR_FLAGS = 8'h0c;
	localparam logic [7:0] CALT_ADDR_RES_LO = 8'h10;
	localparam logic [7:0] CALT_ADDR_RES_HI = 8'h14;
	localparam logic [7:0] CALT_ADDR_STATUS = 8'h18;
	// flag and status bit positions
	localparam int CALT_FLAG_CARRY = 0;
	localparam int CALT_FLAG_AUX = 1;
	localparam int CALT_FLAG_DIVZ = 2;
	localparam int CALT_ST_BUSY = 0;
	localparam int CALT_ST_DONE = 1;
	localparam int CALT_ST_CNT_LSB = 8;
	// timing: one state is two clocks
	localparam int CALT_CLK_NS = 50;
	localparam int CALT_STATE_NS = 2 * CALT_CLK_NS;
	localparam int CALT_CLKS_PER_STATE = CALT_STATE_NS / CALT_CLK_NS;
	localparam int CALT_SW = 8;
	// state counts, binary / source mode
	localparam logic [7:0] CALT_T_SHORT_B = 8'h02;
	localparam logic [7:0] CALT_T_SHORT_S = 8'h01;
	localparam logic [7:0] CALT_T_INCD_B = 8'h04;
	localparam logic [7:0] CALT_T_INCD_S = 8'h03;
	localparam logic [7:0] CALT_T_DECD_B = 8'h05;
	localparam logic [7:0] CALT_T_DECD_S = 8'h04;
	localparam logic [7:0] CALT_T_IND_B = 8'h03;
	localparam logic [7:0] CALT_T_IND_S = 8'h04;
	localparam logic [7:0] CALT_T_DIRRMW = 8'h02;
	localparam logic [7:0] CALT_T_RMW_IO = 8'h02;
	localparam logic [7:0] CALT_T_RMW_PER = 8'h03;
	localparam logic [7:0] CALT_T_ACCDIR = 8'h01;
	localparam logic [7:0] CALT_T_RD_IO = 8'h01;
	localparam logic [7:0] CALT_T_RD_PER = 8'h02;
	localparam logic [7:0] CALT_T_WREG_B = 8'h03;
	localparam logic [7:0] CALT_T_WREG_S = 8'h02;
	localparam logic [7:0] CALT_T_IMM_B = 8'h04;
	localparam logic [7:0] CALT_T_IMM_S = 8'h03;
	localparam logic [7:0] CALT_T_ROT = 8'h01;
	localparam logic [7:0] CALT_T_SWAP = 8'h02;
	localparam logic [7:0] CALT_T_MULAB = 8'h05;
	localparam logic [7:0] CALT_T_MULB_B = 8'h06;
	localparam logic [7:0] CALT_T_MULB_S = 8'h05;
	localparam logic [7:0] CALT_T_MULW_B = 8'h0c;
	localparam logic [7:0] CALT_T_MULW_S = 8'h0b;
	localparam logic [7:0] CALT_T_DIVAB = 8'h0a;
	localparam logic [7:0] CALT_T_DIVB_B = 8'h0b;
	localparam logic [7:0] CALT_T_DIVB_S = 8'h0a;
	localparam logic [7:0] CALT_T_DIVW_B = 8'h15;
	localparam logic [7:0] CALT_T_DIVW_S = 8'h14;
	localparam logic [7:0] CALT_T_DA = 8'h01;
	localparam logic [7:0] CALT_T_EXT_BASE = 8'h02;
	// decimal adjust constants
	localparam logic [3:0] CALT_BCD_MAX = 4'h9;
	localparam logic [3:0] CALT_BCD_FIX = 4'h6;

	typedef enum logic [4:0] {
		CALT_OP_INC_SHORT = 5'b00000,
		CALT_OP_DEC_SHORT = 5'b00001,
		CALT_OP_INC_DWORD = 5'b00010,
		CALT_OP_DEC_DWORD = 5'b00011,
		CALT_OP_INC_IND = 5'b00100,
		CALT_OP_DEC_IND = 5'b00101,
		CALT_OP_INC_DIR = 5'b00110,
		CALT_OP_DEC_DIR = 5'b00111,
		CALT_OP_AND_ACC_DIR = 5'b01000,
		CALT_OP_OR_ACC_DIR = 5'b01001,
		CALT_OP_XOR_ACC_DIR = 5'b01010,
		CALT_OP_AND_WREG = 5'b01011,
		CALT_OP_OR_WREG = 5'b01100,
		CALT_OP_XOR_WREG = 5'b01101,
		CALT_OP_AND_IMM16 = 5'b01110,
		CALT_OP_OR_IMM16 = 5'b01111,
		CALT_OP_XOR_IMM16 = 5'b10000,
		CALT_OP_ROTATE_LEFT = 5'b10001,
		CALT_OP_ROTATE_LEFT_CARRY = 5'b10010,
		CALT_OP_ROTATE_RIGHT = 5'b10011,
		CALT_OP_ROTATE_RIGHT_CARRY = 5'b10100,
		CALT_OP_SWAP = 5'b10101,
		CALT_OP_SHIFT_LEFT_LOGICAL = 5'b10110,
		CALT_OP_SHIFT_RIGHT_ARITH = 5'b10111,
		CALT_OP_SHIFT_RIGHT_LOGICAL = 5'b11000,
		CALT_OP_MUL_AB = 5'b11001,
		CALT_OP_MUL_REG = 5'b11010,
		CALT_OP_DIV_AB = 5'b11011,
		CALT_OP_DIV_REG = 5'b11100,
		CALT_OP_DECIMAL_ADJUST = 5'b11101
	} calt_op_e;

	typedef enum logic [1:0] {
		CALT_LOC_INTERNAL = 2'b00,
		CALT_LOC_IO_PORT = 2'b01,
		CALT_LOC_PERIPH = 2'b10,
		CALT_LOC_EXTERNAL = 2'b11
	} calt_loc_e;

	// control word, bit 15 down to bit 0
	typedef struct packed {
		logic word_size;
		logic [3:0] wait_states;
		logic [1:0] step;
		logic start;
		calt_loc_e loc;
		logic source_mode;
		calt_op_e op;
	} calt_ctrl_s;

	localparam logic [15:0] CALT_CTRL_RST = 16'h0000;
	localparam logic [1:0] CALT_STEP_2 = 2'b01;
	localparam logic [1:0] CALT_STEP_4 = 2'b10;
endpackage

// file: rtl/calt_state_timer.sv
// state counter: holds busy for a number of two-clock states
`timescale 1ns/1ps
module calt_state_timer #(
	parameter int SW = 8,
	parameter int CPS = 2
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst_b,
	// control
	input wire logic load,
	input wire logic [SW-1:0] states,
	// status
	output logic busy,
	output logic done
);
	logic [SW-1:0] remain_r;
	logic [7:0] phase_r;
	logic last_phase;

	assign last_phase = (phase_r == 8'(CPS - 1));

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			busy <= 1'b0;
			remain_r <= '0;
			phase_r <= 8'h00;
		end else if (load && !busy) begin
			busy <= 1'b1;
			remain_r <= states;
			phase_r <= 8'h00;
		end else if (busy) begin
			// every state is CPS clocks long
			if (last_phase) begin
				phase_r <= 8'h00;
				remain_r <= remain_r - 1'b1;
				if (remain_r <= 1)
					busy <= 1'b0;
			end else begin
				phase_r <= phase_r + 8'h01;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_b)
			done <= 1'b0;
		else
			done <= busy && last_phase && (remain_r <= 1);
	end
endmodule // calt_state_timer

// file: test/calt_alu_assertions.sv
// concurrent checks on the apb and busy ports of the alu timing unit
`timescale 1ns/1ps
module calt_alu_assertions (
	// clock and reset
	input wire logic clk,
	input wire logic rst_b,
	// apb
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	// status
	input wire logic busy
);
	logic [7:0] blen_r;
	logic acc;
	logic start;
	logic bad;
	assign acc = psel && penable;
	assign start = acc && pwrite && paddr == calt_pkg::CALT_ADDR_CTRL && pwdata[8] && !busy;
	assign bad = paddr > 8'h18 || paddr[1:0] != 2'b00;
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_b);
	// busy run length, checked as the run ends
	always_ff @(posedge clk) begin
		if (!rst_b || !busy) begin
			blen_r <= 8'h00;
		end else begin
			blen_r <= blen_r + 8'h01;
		end
	end
	chk_reset_idle: assert property ($past(rst_b) == 1'b0 |-> !busy && !pslverr && prdata == 32'h0)
		else $error("outputs not idle after reset");
	chk_busy_start: assert property (start |=> busy)
		else $error("start did not raise busy");
	chk_busy_even: assert property (!busy && $past(busy) |-> !blen_r[0] && blen_r >= 8'h02)
		else $error("busy run not whole states");
	chk_busy_bound: assert property (start |-> ##[2:112] !busy)
		else $error("busy run too long");
	chk_err_unmapped: assert property (acc && bad |-> pslverr)
		else $error("no error on unmapped access");
	chk_err_mapped: assert property (acc && !bad |-> !pslverr)
		else $error("error on mapped access");
	chk_write_zero: assert property (acc && pwrite |-> prdata == 32'h0)
		else $error("read data not zero on write");
	chk_status_busy: assert property (acc && !pwrite && paddr == 8'h18 |-> prdata[0] == $past(busy))
		else $error("status busy bit wrong");
	chk_ready_high: assert property (psel |-> pready)
		else $error("pready low");
	cover property ($rose(busy));
	cover property (acc && bad);
	cover property (acc && !pwrite && paddr == 8'h18 && prdata[0]);
endmodule // calt_alu_assertions

bind calt_alu calt_alu_assertions chk (.clk(clk), .rst_b(rst_b), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
	.pslverr(pslverr), .busy(busy));

// file: test/tb.sv
// self-checking bench for the alu timing unit
`timescale 1ns/1ps
module tb;
	logic clk = 1'b0;
	logic rst_b = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic busy;
	int failures = 0;
	int samples_checked = 0;
	logic [15:0] lf = 16'h2445;
	logic [31:0] last_res = 32'h0;
	logic [31:0] rd;
	logic er;
	// increment step code driven into the control word
	logic [1:0] stp = 2'b00;

	always #25 clk = ~clk;

	calt_alu dut (.clk(clk), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.busy(busy));

	task automatic close_out();
		$display("checked %0d failures %0d", samples_checked, failures);
		if (failures == 0 && samples_checked > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask

	task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			failures++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic chk_count(input int got, input int exp);
		samples_checked++;
		if (got != exp) begin
			failures++;
			$display("ERROR t=%0t cycles got=%h exp=%h", $time, got, exp);
		end
	endtask

	// lfsr source, two steps per word
	function logic [31:0] rnd();
		lf = {lf[14:0], lf[15] ^ lf[13] ^ lf[12] ^ lf[10]};
		rnd[31:16] = lf;
		lf = {lf[14:0], lf[15] ^ lf[13] ^ lf[12] ^ lf[10]};
		rnd[15:0] = lf;
	endfunction

	task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		@(posedge clk);
		while (pready !== 1'b1) @(posedge clk);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	function automatic int exp_states(input logic [4:0] op, input logic sm,
		input logic [1:0] loc, input logic [3:0] ws, input logic wd);
		int s;
		int ex;
		ex = (loc == 2'b01) ? 1 : (loc == 2'b10) ? 2 : 0;
		case (op)
			5'h00, 5'h01, 5'h16, 5'h17, 5'h18: s = sm ? 1 : 2;
			5'h02: s = sm ? 3 : 4;
			5'h03: s = sm ? 4 : 5;
			5'h04, 5'h05: s = sm ? 4 : 3;
			5'h06, 5'h07: s = 2 + ex + int'(ex != 0);
			5'h08, 5'h09, 5'h0a: s = 1 + ex;
			5'h0b, 5'h0c, 5'h0d: s = sm ? 2 : 3;
			5'h0e, 5'h0f, 5'h10: s = sm ? 3 : 4;
			5'h11, 5'h12, 5'h13, 5'h14, 5'h1d: s = 1;
			5'h15: s = 2;
			5'h19: s = 5;
			5'h1a: s = wd ? (sm ? 11 : 12) : (sm ? 5 : 6);
			5'h1b: s = 10;
			5'h1c: s = wd ? (sm ? 20 : 21) : (sm ? 10 : 11);
			default: s = 0;
		endcase
		if (loc == 2'b11) s += wd ? 2 * (int'(ws) + 2) : int'(ws) + 2;
		return s;
	endfunction

	function automatic logic [31:0] exp_res(input logic [4:0] op, input logic [31:0] a,
		input logic [31:0] b, input logic cy, input logic ac, input logic wd,
		output logic c, output logic [31:0] m);
		logic [7:0] x;
		logic [8:0] t;
		logic [31:0] r;
		logic [31:0] v;
		x = a[7:0];
		v = (stp == 2'b01) ? 32'h2 : (stp == 2'b10) ? 32'h4 : 32'h1;
		c = cy;
		m = 32'h0000ffff;
		r = 32'h0;
		case (op)
			5'h00, 5'h02: r = a + v;
			5'h01, 5'h03: r = a - v;
			5'h04, 5'h06: r = {24'h0, x + 8'h01};
			5'h05, 5'h07: r = {24'h0, x - 8'h01};
			5'h08, 5'h0b, 5'h0e: r = a & b;
			5'h09, 5'h0c, 5'h0f: r = a | b;
			5'h0a, 5'h0d, 5'h10: r = a ^ b;
			5'h11: r = {24'h0, x[6:0], x[7]};
			5'h12: {c, r[7:0]} = {x, cy};
			5'h13: r = {24'h0, x[0], x[7:1]};
			5'h14: {r[7:0], c} = {cy, x};
			5'h15: r = {24'h0, x[3:0], x[7:4]};
			5'h16: r = wd ? {16'h0, a[14:0], 1'b0} : {24'h0, x[6:0], 1'b0};
			5'h17: r = wd ? {16'h0, a[15], a[15:1]} : {24'h0, x[7], x[7:1]};
			5'h18: r = wd ? {17'h0, a[15:1]} : {25'h0, x[7:1]};
			5'h19: r = x * b[7:0];
			5'h1a: r = wd ? a[15:0] * b[15:0] : x * b[7:0];
			5'h1b: r = {16'h0, x % b[7:0], x / b[7:0]};
			5'h1c: r = wd ? {a[15:0] / b[15:0], a[15:0] % b[15:0]} : {16'h0, x / b[7:0], x % b[7:0]};
			5'h1d: begin
				t = {1'b0, x};
				if (t[3:0] > 4'h9 || ac) t = t + 9'h006;
				c = cy | t[8];
				if (t[7:4] > 4'h9 || c) t = {1'b0, t[7:0]} + 9'h060;
				c = c | t[8];
				r = {24'h0, t[7:0]};
			end
			default: m = 32'h0;
		endcase
		if (op inside {[5'h04:5'h0a], [5'h11:5'h15], 5'h1d}) m = 32'hff;
		if (!wd && op inside {5'h00, 5'h01, [5'h16:5'h18]}) m = 32'hff;
		if (op inside {5'h02, 5'h03} || (wd && op inside {5'h1a, 5'h1c})) m = 32'hffffffff;
		return r;
	endfunction

	task automatic launch(input logic [4:0] op, input logic sm, input logic [1:0] loc,
		input logic [3:0] ws, input logic wd);
		apb(8'h00, 1'b1, {16'h0, wd, ws, stp, 1'b1, loc, sm, op});
	endtask

	// refuse: a second start and an operand write land while busy, both must be ignored
	task automatic run_op(input logic [4:0] op, input logic [31:0] a, input logic [31:0] b,
		input logic [1:0] fl, input logic sm, input logic [1:0] loc, input logic [3:0] ws,
		input logic wd, input logic refuse);
		logic [31:0] e;
		logic [31:0] m;
		logic c;
		logic dz;
		int s;
		int n;
		int i;
		e = exp_res(op, a, b, fl[0], fl[1], wd, c, m);
		dz = (op == 5'h1b || op == 5'h1c) && (wd && op == 5'h1c ? b[15:0] == 16'h0 : b[7:0] == 8'h00);
		if (dz) begin
			e = last_res;
			m = 32'hffffffff;
		end
		s = exp_states(op, sm, loc, ws, wd);
		apb(8'h04, 1'b1, a);
		apb(8'h08, 1'b1, b);
		apb(8'h0c, 1'b1, {30'h0, fl});
		launch(op, sm, loc, ws, wd);
		if (refuse) begin
			launch(5'h11, 1'b1, 2'b00, 4'h0, 1'b0);
			apb(8'h04, 1'b1, ~a);
		end
		n = 0;
		for (i = 0; i < 300; i++) begin
			@(negedge clk);
			if (busy === 1'b1) n++;
			else if (n > 0) break;
		end
		chk_count(n, 2 * s - (refuse ? 6 : 0));
		@(posedge clk);
		apb(8'h10, 1'b0, 32'h0);
		if (m != 32'h0) chk_word(rd & m, e & m);
		last_res = rd;
		apb(8'h14, 1'b0, 32'h0);
		chk_word(rd, a);
		apb(8'h0c, 1'b0, 32'h0);
		chk_word({30'h0, rd[2], rd[0]}, {30'h0, dz, c});
		apb(8'h18, 1'b0, 32'h0);
		chk_word({16'h0, rd[15:0]}, {16'h0, s[7:0], 8'h02});
		// sticky done must clear on a write of one
		apb(8'h18, 1'b1, 32'h2);
		apb(8'h18, 1'b0, 32'h0);
		chk_word(rd & 32'h3, 32'h0);
	endtask

	initial begin
		repeat (60000) @(posedge clk);
		failures++;
		close_out();
	end

	initial begin
		int i;
		logic [31:0] a;
		logic [31:0] b;
		logic [31:0] r;
		repeat (5) @(posedge clk);
		rst_b <= 1'b1;
		for (i = 0; i < 8; i++) begin
			apb(8'(4 * i), 1'b0, 32'h0);
			if (i < 7) chk_word(rd, 32'h0);
			chk_word({31'h0, er}, {31'h0, i == 7});
		end
		apb(8'h40, 1'b1, 32'hffffffff);
		chk_word({31'h0, er}, 32'h1);
		// corner cases first, then every opcode three times at random
		run_op(5'h1d, 32'h9a, 32'h0, 2'b00, 1'b0, 2'b00, 4'h0, 1'b0, 1'b0);
		run_op(5'h1d, 32'h99, 32'h0, 2'b10, 1'b1, 2'b00, 4'h0, 1'b0, 1'b0);
		run_op(5'h1d, 32'h3a, 32'h0, 2'b01, 1'b0, 2'b00, 4'h0, 1'b0, 1'b0);
		run_op(5'h1b, 32'h5c, 32'h0, 2'b00, 1'b1, 2'b10, 4'h0, 1'b0, 1'b0);
		run_op(5'h1c, 32'hbeef, 32'h12, 2'b01, 1'b0, 2'b11, 4'hf, 1'b1, 1'b1);
		for (i = 0; i < 90; i++) begin
			a = rnd();
			b = rnd();
			r = rnd();
			stp = r[11:10];
			run_op(5'(i % 30), a, b, r[1:0], r[2], r[4:3], r[8:5], r[9], 1'b0);
		end
		close_out();
	end
endmodule // tb
